// ---- core/acs_top.sv ----
module acs_top (
   input  wire logic        clock,
   input  wire logic        reset_n,
   input  wire logic [4:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [4:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        modulator_bit,
   output logic             modulator_clear,
   output logic             chop_polarity,
   output logic             busy,
   output logic [3:0]       stage_enable,
   output logic [1:0]       converter_bias_sel,
   output logic [1:0]       amp_chain_bias_sel
);
   logic [4:0]  aw_addr, next_aw_addr;
   logic [7:0]  w_byte, next_w_byte;
   logic        aw_full, next_aw_full, w_full, next_w_full, w_en, next_w_en;
   logic        next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
   logic [1:0]  next_bresp, next_rresp;
   logic [31:0] next_rdata;
   logic [2:0]  oversample_ratio_sel, next_osr_sel;
   logic [1:0]  elem_conv_count_sel, next_nelc_sel, sample_clock_sel, next_fsel;
   logic [1:0]  next_cbias, next_abias;
   logic [3:0]  next_enable;
   logic        cont, next_cont, start_req, next_start_req;
   logic        wr_do, start_set;
   // Conversion core state
   acs_pkg::acs_state_t state, next_state;
   logic [2:0]  cur_osr, next_cur_osr;
   logic [1:0]  cur_nelc, next_cur_nelc;
   logic [10:0] period, next_period;
   logic [3:0]  elem_idx, next_elem_idx;
   logic signed [11:0] integ1, next_integ1;
   logic signed [21:0] integ2, next_integ2;
   logic signed [26:0] total, next_total;
   logic [15:0] result_word, next_result;
   logic        next_busy, next_chop, next_mclear, tick, div_restart;
   logic [10:0] osr_cur_val, osr_val;
   logic [3:0]  elem_conv_total;
   logic [4:0]  nraw, res, fill_w;
   logic [1:0]  lim_c, lim_a, eff_fsel;
   logic signed [31:0] wide, scaled;
   logic [15:0] sat;

   assign osr_val = 11'h008 << oversample_ratio_sel;
   assign osr_cur_val = 11'h008 << cur_osr;
   assign elem_conv_total = 4'h1 << cur_nelc;
   assign nraw = 5'(2 * (acs_pkg::OSR_EXP_BASE + 32'(cur_osr)) + 32'(cur_nelc));
   assign res = (nraw > 5'(acs_pkg::RES_MAX)) ? 5'(acs_pkg::RES_MAX) : nraw;
   // Fill width capped; at the lowest resolutions the forced one still sits in bit 8
   assign fill_w = (5'(acs_pkg::RES_MAX) - res > 5'(acs_pkg::FILL_MAX)) ?
                   5'(acs_pkg::FILL_MAX) : 5'(acs_pkg::RES_MAX) - res;

   // Bias codes cap the sample clock; slowest of the two wins
   always_comb begin
      lim_c = (converter_bias_sel == acs_pkg::BIAS_QTR) ? acs_pkg::FSEL_125K :
              (converter_bias_sel == acs_pkg::BIAS_HALF) ? acs_pkg::FSEL_250K :
              acs_pkg::FSEL_500K;
      lim_a = (amp_chain_bias_sel == acs_pkg::BIAS_QTR) ? acs_pkg::FSEL_125K :
              (amp_chain_bias_sel == acs_pkg::BIAS_HALF) ? acs_pkg::FSEL_250K :
              acs_pkg::FSEL_500K;
      eff_fsel = sample_clock_sel;
      if (eff_fsel > lim_c) begin
         eff_fsel = lim_c;
      end
      if (eff_fsel > lim_a) begin
         eff_fsel = lim_a;
      end
   end

   acs_rate_div u_div (
      .clock   (clock),
      .reset_n (reset_n),
      .restart (div_restart),
      .sel     (eff_fsel),
      .tick    (tick)
   );

   // Bus slave and configuration registers
   always_comb begin
      next_aw_addr  = aw_addr;
      next_w_byte   = w_byte;
      next_w_en     = w_en;
      next_aw_full  = aw_full | (s_axi_awvalid & s_axi_awready);
      next_w_full   = w_full | (s_axi_wvalid & s_axi_wready);
      next_bvalid   = s_axi_bvalid & ~s_axi_bready;
      next_bresp    = s_axi_bresp;
      next_rvalid   = s_axi_rvalid & ~s_axi_rready;
      next_rdata    = s_axi_rdata;
      next_rresp    = s_axi_rresp;
      next_osr_sel  = oversample_ratio_sel;
      next_nelc_sel = elem_conv_count_sel;
      next_cont     = cont;
      next_cbias    = converter_bias_sel;
      next_abias    = amp_chain_bias_sel;
      next_enable   = stage_enable;
      next_fsel     = sample_clock_sel;
      start_set     = 1'b0;
      if (s_axi_awvalid & s_axi_awready) begin
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
         next_w_byte = s_axi_wdata[7:0];
         next_w_en   = s_axi_wstrb[0];
      end
      wr_do = aw_full & w_full & ~s_axi_bvalid;
      if (wr_do) begin
         next_aw_full = 1'b0;
         next_w_full  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = acs_pkg::RESP_OKAY;
         if (aw_addr == acs_pkg::OFF_CTRL) begin
            if (w_en) begin
               next_nelc_sel = w_byte[acs_pkg::POS_NELC +: 2];
               next_osr_sel  = w_byte[acs_pkg::POS_OSR +: 3];
               next_cont     = w_byte[acs_pkg::POS_CONT];
               start_set     = w_byte[acs_pkg::POS_START];
            end
         end else if (aw_addr == acs_pkg::OFF_POWER) begin
            if (w_en) begin
               next_cbias  = w_byte[acs_pkg::POS_CBIAS +: 2];
               next_abias  = w_byte[acs_pkg::POS_ABIAS +: 2];
               next_enable = w_byte[acs_pkg::POS_ENABLE +: 4];
            end
         end else if (aw_addr == acs_pkg::OFF_CLOCK) begin
            if (w_en) begin
               next_fsel = w_byte[acs_pkg::POS_FSEL +: 2];
            end
         end else if (aw_addr == acs_pkg::OFF_STATUS) begin
            if (w_en && w_byte[acs_pkg::POS_DEFCFG]) begin
               next_nelc_sel = acs_pkg::RST_NELC;
               next_osr_sel  = acs_pkg::RST_OSR;
               next_cbias    = acs_pkg::RST_BIAS;
               next_abias    = acs_pkg::RST_BIAS;
               next_fsel     = acs_pkg::RST_FSEL;
               start_set     = 1'b1;
            end
         end else if (aw_addr != acs_pkg::OFF_RESULT) begin
            next_bresp = acs_pkg::RESP_SLVERR;
         end
      end
      next_awready = ~next_aw_full;
      next_wready  = ~next_w_full;
      if (s_axi_arvalid & s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rresp  = acs_pkg::RESP_OKAY;
         next_rdata  = 32'h0000_0000;
         if (s_axi_araddr == acs_pkg::OFF_CTRL) begin
            next_rdata = {24'h00_0000, start_req, elem_conv_count_sel,
                          oversample_ratio_sel, cont, 1'b0};
         end else if (s_axi_araddr == acs_pkg::OFF_POWER) begin
            next_rdata = {24'h00_0000, converter_bias_sel, amp_chain_bias_sel, stage_enable};
         end else if (s_axi_araddr == acs_pkg::OFF_CLOCK) begin
            next_rdata = {24'h00_0000, sample_clock_sel, 6'h00};
         end else if (s_axi_araddr == acs_pkg::OFF_STATUS) begin
            next_rdata = {24'h00_0000, busy, 7'h00};
         end else if (s_axi_araddr == acs_pkg::OFF_RESULT) begin
            next_rdata = {16'h0000, result_word};
         end else begin
            next_rresp = acs_pkg::RESP_SLVERR;
         end
      end
      next_arready = ~next_rvalid;
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         aw_addr              <= 5'h00;
         w_byte               <= 8'h00;
         w_en                 <= 1'b0;
         aw_full              <= 1'b0;
         w_full               <= 1'b0;
         s_axi_awready        <= 1'b1;
         s_axi_wready         <= 1'b1;
         s_axi_bvalid         <= 1'b0;
         s_axi_bresp          <= 2'h0;
         s_axi_arready        <= 1'b1;
         s_axi_rvalid         <= 1'b0;
         s_axi_rdata          <= 32'h0000_0000;
         s_axi_rresp          <= 2'h0;
         oversample_ratio_sel <= acs_pkg::RST_OSR;
         elem_conv_count_sel  <= acs_pkg::RST_NELC;
         cont                 <= 1'b0;
         converter_bias_sel   <= acs_pkg::RST_BIAS;
         amp_chain_bias_sel   <= acs_pkg::RST_BIAS;
         stage_enable         <= acs_pkg::RST_ENABLE;
         sample_clock_sel     <= acs_pkg::RST_FSEL;
      end else begin
         aw_addr              <= next_aw_addr;
         w_byte               <= next_w_byte;
         w_en                 <= next_w_en;
         aw_full              <= next_aw_full;
         w_full               <= next_w_full;
         s_axi_awready        <= next_awready;
         s_axi_wready         <= next_wready;
         s_axi_bvalid         <= next_bvalid;
         s_axi_bresp          <= next_bresp;
         s_axi_arready        <= next_arready;
         s_axi_rvalid         <= next_rvalid;
         s_axi_rdata          <= next_rdata;
         s_axi_rresp          <= next_rresp;
         oversample_ratio_sel <= next_osr_sel;
         elem_conv_count_sel  <= next_nelc_sel;
         cont                 <= next_cont;
         converter_bias_sel   <= next_cbias;
         amp_chain_bias_sel   <= next_abias;
         stage_enable         <= next_enable;
         sample_clock_sel     <= next_fsel;
      end
   end

   // Result scaling, clamp and fill pattern
   always_comb begin
      wide = 32'(total);
      if (nraw <= 5'(acs_pkg::RES_MAX)) begin
         scaled = wide <<< (5'(acs_pkg::RES_MAX) - nraw);
      end else begin
         scaled = wide >>> (nraw - 5'(acs_pkg::RES_MAX));
      end
      if (scaled > 32'sd32767) begin
         sat = 16'h7fff;
      end else if (scaled < -32'sd32768) begin
         sat = 16'h8000;
      end else begin
         sat = scaled[15:0];
      end
      for (int b = 0; b < acs_pkg::FILL_MAX; b++) begin
         if (5'(b) < fill_w) begin
            sat[b] = (5'(b) == fill_w - 5'h01);
         end
      end
   end

   // Sequencer; ratio and count latched at start so a rewrite cannot corrupt a running conversion
   always_comb begin
      next_state     = state;
      next_cur_osr   = cur_osr;
      next_cur_nelc  = cur_nelc;
      next_period    = period;
      next_elem_idx  = elem_idx;
      next_integ1    = integ1;
      next_integ2    = integ2;
      next_total     = total;
      next_result    = result_word;
      next_busy      = busy;
      next_chop      = chop_polarity;
      next_mclear    = modulator_clear;
      next_start_req = start_req | start_set;
      div_restart    = 1'b0;
      case (state)
         acs_pkg::ST_IDLE: begin
            if (start_req) begin
               next_state     = acs_pkg::ST_ELEM;
               next_start_req = start_set;
               next_cur_osr   = oversample_ratio_sel;
               next_cur_nelc  = elem_conv_count_sel;
               next_period    = 11'h000;
               next_elem_idx  = 4'h0;
               next_total     = 27'sh0;
               next_busy      = 1'b1;
               next_chop      = 1'b0;
               next_mclear    = 1'b1;
               div_restart    = 1'b1;
            end
         end
         acs_pkg::ST_ELEM: begin
            if (tick) begin
               next_mclear = 1'b0;
               if (period == 11'h000) begin
                  next_integ1 = 12'sh0;
                  next_integ2 = 22'sh0;
               end else begin
                  next_integ1 = integ1 + (modulator_bit ? 12'sh1 : -12'sh1);
                  next_integ2 = integ2 + 22'(next_integ1);
               end
               next_period = period + 11'h001;
               if (period == osr_cur_val) begin
                  next_period   = 11'h000;
                  next_mclear   = 1'b1;
                  next_chop     = ~chop_polarity;
                  next_elem_idx = elem_idx + 4'h1;
                  next_total    = chop_polarity ? total - 27'(next_integ2)
                                                : total + 27'(next_integ2);
                  if (elem_idx + 4'h1 == elem_conv_total) begin
                     next_state = acs_pkg::ST_FINAL;
                  end
               end
            end
         end
         acs_pkg::ST_FINAL: begin
            if (tick) begin
               next_result = sat;
               next_busy   = 1'b0;
               next_state  = acs_pkg::ST_IDLE;
               next_mclear = 1'b0;
               if (cont) begin
                  next_start_req = 1'b1;
               end
            end
         end
         default: next_state = acs_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state           <= acs_pkg::ST_IDLE;
         cur_osr         <= 3'h0;
         cur_nelc        <= 2'h0;
         period          <= 11'h000;
         elem_idx        <= 4'h0;
         integ1          <= 12'sh0;
         integ2          <= 22'sh0;
         total           <= 27'sh0;
         result_word     <= 16'h0000;
         busy            <= 1'b0;
         chop_polarity   <= 1'b0;
         modulator_clear <= 1'b0;
         start_req       <= 1'b0;
      end else begin
         state           <= next_state;
         cur_osr         <= next_cur_osr;
         cur_nelc        <= next_cur_nelc;
         period          <= next_period;
         elem_idx        <= next_elem_idx;
         integ1          <= next_integ1;
         integ2          <= next_integ2;
         total           <= next_total;
         result_word     <= next_result;
         busy            <= next_busy;
         chop_polarity   <= next_chop;
         modulator_clear <= next_mclear;
         start_req       <= next_start_req;
      end
   end

   // Helper: sample periods counted over one conversion
   logic [13:0] tick_cnt;
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         tick_cnt <= 14'h0000;
      end else if (!busy) begin
         tick_cnt <= 14'h0000;
      end else if (tick) begin
         tick_cnt <= tick_cnt + 14'h0001;
      end
   end

   sequence s_final_tick;
      state == acs_pkg::ST_FINAL && tick;
   endsequence

   a_ratio_decode: assert property (@(posedge clock) disable iff (!reset_n)
      osr_val == (11'h001 << (4'(oversample_ratio_sel) + 4'h3))) else $error("ratio");
   a_count_decode: assert property (@(posedge clock) disable iff (!reset_n)
      elem_conv_total >= 4'h1 && elem_conv_total <= 4'h8) else $error("count");
   a_res_cap: assert property (@(posedge clock) disable iff (!reset_n)
      res <= 5'd16 && (nraw < 5'd16 || res == 5'd16)) else $error("resolution");
   a_conv_length: assert property (@(posedge clock) disable iff (!reset_n)
      s_final_tick |-> 14'(tick_cnt + 14'h0001) ==
         14'(elem_conv_total) * (14'(osr_cur_val) + 14'h0001) + 14'h0001)
      else $error("length");
   a_clamp_pos: assert property (@(posedge clock) disable iff (!reset_n)
      s_final_tick and (scaled > 32'sd32767)
      |=> (result_word | ((16'h0001 << fill_w) - 16'h0001)) == 16'h7fff)
      else $error("pos");
   a_clamp_neg: assert property (@(posedge clock) disable iff (!reset_n)
      s_final_tick and (scaled < -32'sd32768)
      |=> (result_word & ~((16'h0001 << fill_w) - 16'h0001)) == 16'h8000)
      else $error("neg");
   a_fill_pattern: assert property (@(posedge clock) disable iff (!reset_n)
      s_final_tick and (fill_w != 5'h00)
      |=> (result_word & ((16'h0001 << fill_w) - 16'h0001)) ==
          (16'h0001 << (fill_w - 5'h01))) else $error("fill");
   a_bias_limit: assert property (@(posedge clock) disable iff (!reset_n)
      eff_fsel <= lim_c && eff_fsel <= lim_a) else $error("bias limit");
   a_start_busy: assert property (@(posedge clock) disable iff (!reset_n)
      state == acs_pkg::ST_IDLE && start_req |=> busy ##1 busy) else $error("start");
   a_chop_toggle: assert property (@(posedge clock) disable iff (!reset_n)
      state == acs_pkg::ST_ELEM && tick && period == osr_cur_val
      |=> chop_polarity != $past(chop_polarity)) else $error("chop");
   a_result_hold: assert property (@(posedge clock) disable iff (!reset_n)
      busy && !(state == acs_pkg::ST_FINAL && tick) |=> $stable(result_word))
      else $error("result moved");
endmodule

// ---- core/acs_pkg.sv ----
package acs_pkg;
   // Register byte offsets
   localparam logic [4:0]  OFF_CTRL    = 5'h00;
   localparam logic [4:0]  OFF_POWER   = 5'h04;
   localparam logic [4:0]  OFF_CLOCK   = 5'h08;
   localparam logic [4:0]  OFF_STATUS  = 5'h0c;
   localparam logic [4:0]  OFF_RESULT  = 5'h10;
   // Field positions, control register
   localparam int          POS_START   = 7;
   localparam int          POS_NELC    = 5;
   localparam int          POS_OSR     = 2;
   localparam int          POS_CONT    = 1;
   // Field positions, power and clock registers
   localparam int          POS_CBIAS   = 6;
   localparam int          POS_ABIAS   = 4;
   localparam int          POS_ENABLE  = 0;
   localparam int          POS_FSEL    = 6;
   // Field positions, status register
   localparam int          POS_BUSY    = 7;
   localparam int          POS_DEFCFG  = 6;
   // Values after reset, also the default configuration except RST_ENABLE
   localparam logic [1:0]  RST_NELC    = 2'h1;
   localparam logic [2:0]  RST_OSR     = 3'h2;
   localparam logic [1:0]  RST_BIAS    = 2'h3;
   localparam logic [3:0]  RST_ENABLE  = 4'h0;
   localparam logic [1:0]  RST_FSEL    = 2'h0;
   // Ratio exponent base, resolution and fill width caps
   localparam int          OSR_EXP_BASE = 3;
   localparam int          RES_MAX      = 16;
   localparam int          FILL_MAX     = 9;
   // Timing
   localparam int          CLK_HZ      = 50_000_000;
   localparam int          FS0_HZ      = 62_500;
   localparam int          FS1_HZ      = 125_000;
   localparam int          FS2_HZ      = 250_000;
   localparam int          FS3_HZ      = 500_000;
   localparam int          DIV0        = CLK_HZ / FS0_HZ;
   localparam int          DIV1        = CLK_HZ / FS1_HZ;
   localparam int          DIV2        = CLK_HZ / FS2_HZ;
   localparam int          DIV3        = CLK_HZ / FS3_HZ;
   // Bias code to highest allowed clock select, then bus response codes
   localparam logic [1:0]  BIAS_QTR    = 2'h0;
   localparam logic [1:0]  BIAS_HALF   = 2'h1;
   localparam logic [1:0]  FSEL_125K   = 2'h1;
   localparam logic [1:0]  FSEL_250K   = 2'h2;
   localparam logic [1:0]  FSEL_500K   = 2'h3;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_ELEM  = 3'b010,
      ST_FINAL = 3'b100
   } acs_state_t;
endpackage

// ---- core/acs_rate_div.sv ----
module acs_rate_div (
   input  wire logic       clock,
   input  wire logic       reset_n,
   input  wire logic       restart,
   input  wire logic [1:0] sel,
   output logic            tick
);
   logic [9:0] count;
   logic [9:0] next_count;
   logic       next_tick;
   logic [9:0] limit;

   always_comb begin
      case (sel)
         2'h0:    limit = 10'(acs_pkg::DIV0 - 1);
         2'h1:    limit = 10'(acs_pkg::DIV1 - 1);
         2'h2:    limit = 10'(acs_pkg::DIV2 - 1);
         default: limit = 10'(acs_pkg::DIV3 - 1);
      endcase
      next_tick  = 1'b0;
      next_count = count - 10'h001;
      if (restart) begin
         next_count = limit;
      end else if (count == 10'h000) begin
         next_tick  = 1'b1;
         next_count = limit;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         count <= 10'h000;
         tick  <= 1'b0;
      end else begin
         count <= next_count;
         tick  <= next_tick;
      end
   end
endmodule

// ---- dv/acs_host.sv ----
module acs_host (
   input  wire logic        clock,
   output logic [4:0]       s_axi_awaddr,
   output logic             s_axi_awvalid,
   input  wire logic        s_axi_awready,
   output logic [31:0]      s_axi_wdata,
   output logic [3:0]       s_axi_wstrb,
   output logic             s_axi_wvalid,
   input  wire logic        s_axi_wready,
   input  wire logic [1:0]  s_axi_bresp,
   input  wire logic        s_axi_bvalid,
   output logic             s_axi_bready,
   output logic [4:0]       s_axi_araddr,
   output logic             s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic [31:0] s_axi_rdata,
   input  wire logic [1:0]  s_axi_rresp,
   input  wire logic        s_axi_rvalid,
   output logic             s_axi_rready
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 42'h00000000000;
      s_axi_wstrb = 4'hf;
   end
   // One access at a time, ending when bvalid on a write or rvalid on a read is seen
   task automatic xfer(input logic we, input logic [4:0] a, input logic [7:0] d,
                       output logic [31:0] q, output logic [1:0] r);
      logic done;
      done = 1'b0;
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= {24'h000000, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{we}};
      {s_axi_arvalid, s_axi_rready} <= {2{!we}};
      while (!done) begin
         @(posedge clock);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if ((we && s_axi_bvalid) || (!we && s_axi_rvalid)) begin
            q = s_axi_rdata;
            r = we ? s_axi_bresp : s_axi_rresp;
            {s_axi_bready, s_axi_rready} <= 2'h0;
            done = 1'b1;
         end
      end
   endtask
endmodule

// ---- dv/acs_top_tb.sv ----
module acs_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock = 1'b0;
   logic        reset_n = 1'b0;
   logic        modulator_bit = 1'b0;
   logic [4:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, q;
   logic [3:0]  s_axi_wstrb, stage_enable;
   logic [1:0]  s_axi_bresp, s_axi_rresp, converter_bias_sel, amp_chain_bias_sel, rs;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic        modulator_clear, chop_polarity, busy;
   int          bad_count = 0;
   int          cmp_count = 0;
   acs_top u_acs_top (.clock, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .modulator_bit, .modulator_clear,
      .chop_polarity, .busy, .stage_enable, .converter_bias_sel, .amp_chain_bias_sel);
   acs_host u_acs_host (.clock, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);
   initial forever #10 clock = ~clock;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic rchk(input logic [4:0] a, input logic [29:0] e, input logic [1:0] er);
      u_acs_host.xfer(1'b0, a, 8'h00, q, rs);
      check({rs, q[29:0]}, {er, e});
   endtask
   task automatic measure(input int osr, input int nel, input int eff, input logic bv);
      int fill, cnt;
      logic [31:0] mask, base;
      fill = 16 - 2 * (3 + osr) - nel;
      fill = (fill > 9) ? 9 : fill;
      mask = (fill > 0) ? (32'h1 << fill) - 32'h1 : 32'h0;
      // Constant input cancels over an even count of chopped elementary conversions
      base = (nel > 0) ? 32'h0 : (bv ? 32'h00007fff : 32'h00008000);
      cnt = 0;
      while (!busy && cnt < 20) begin
         @(posedge clock);
         cnt++;
      end
      u_acs_host.xfer(1'b0, acs_pkg::OFF_STATUS, 8'h00, q, rs);
      check(q & 32'h80, 32'h80);
      check(modulator_clear, 1'b1);
      cnt = 0;
      while (busy && cnt < 60000) begin
         @(posedge clock);
         cnt++;
      end
      // Rounding hides the few cycles of start and status-read latency
      cnt = (cnt + (acs_pkg::DIV0 >> (eff + 1))) / (acs_pkg::DIV0 >> eff);
      check(cnt, (1 << nel) * ((8 << osr) + 1) + 1);
      check({modulator_clear, chop_polarity}, {1'b0, nel == 0});
      u_acs_host.xfer(1'b0, acs_pkg::OFF_RESULT, 8'h00, q, rs);
      if (fill > 0) check(q & mask, 32'h1 << (fill - 1));
      check(q & ~mask, base & ~mask);
   endtask
   task automatic conv(input logic [2:0] osr, input logic [1:0] nel, input logic [1:0] fs,
                       input logic [1:0] cb, input logic bv);
      modulator_bit <= bv;
      u_acs_host.xfer(1'b1, acs_pkg::OFF_POWER, {cb, 6'h3f}, q, rs);
      check({converter_bias_sel, stage_enable}, {cb, 4'hf});
      u_acs_host.xfer(1'b1, acs_pkg::OFF_CLOCK, {fs, 6'h00}, q, rs);
      u_acs_host.xfer(1'b1, acs_pkg::OFF_CTRL, {1'b1, nel, osr, 2'h0}, q, rs);
      measure(osr, nel, (cb == 2'h0 && fs > 2'h1) ? 1 : int'(fs), bv);
   endtask
   task automatic test_reset();
      rchk(acs_pkg::OFF_CTRL, 30'h28, acs_pkg::RESP_OKAY);
      rchk(acs_pkg::OFF_POWER, 30'hf0, acs_pkg::RESP_OKAY);
      u_acs_host.xfer(1'b1, acs_pkg::OFF_RESULT, 8'h5a, q, rs);
      rchk(acs_pkg::OFF_RESULT, 30'h0, acs_pkg::RESP_OKAY);
      rchk(5'h14, 30'h0, acs_pkg::RESP_SLVERR);
   endtask
   task automatic test_default();
      modulator_bit <= 1'b1;
      u_acs_host.xfer(1'b1, acs_pkg::OFF_STATUS, 8'h40, q, rs);
      measure(2, 1, 0, 1'b1);
      rchk(acs_pkg::OFF_CTRL, 30'h28, acs_pkg::RESP_OKAY);
      rchk(acs_pkg::OFF_CLOCK, 30'h0, acs_pkg::RESP_OKAY);
   endtask
   initial begin
      repeat (6) @(posedge clock);
      reset_n <= 1'b1;
      test_reset();
      conv(3'h0, 2'h0, 2'h3, 2'h3, 1'b1);
      conv(3'h1, 2'h1, 2'h3, 2'h3, 1'b1);
      conv(3'h0, 2'h0, 2'h3, 2'h0, 1'b1);
      conv(3'h5, 2'h0, 2'h3, 2'h3, 1'b0);
      test_default();
      finish_test();
   end
   initial begin
      repeat (99000) @(posedge clock);
      bad_count++;
      finish_test();
   end
endmodule
